// [logic/uart_control.sv]
// Serial port control, baud generator, framer and AHB-Lite register slave
// Operation
// - Transmitter off aborts sending, empties buffers, releases TX pin.
// - TX pin is driven only while transmitter and unit are both on.
// - Receiver off aborts reception and releases RX pin; received data and its flags are kept.
// - RX pin is owned only while receiver and unit are both on.
// - Bit rate is clock over 64(N+1), or 16(N+1) in high speed.
// - Free-running 8-bit counter reloads from divisor N, 0 to 255.
// - With address detect, words with address bit set are kept, interrupting.
// - With address detect, words with address bit clear are dropped silently.
// - Wake enabled in low power: RX falling edge wakes the device.
// - Wake disabled: RX edges never wake the device.
// - Receive enable lets overrun or data-available set the interrupt.
// - Idle enable lets transmitter-idle set the interrupt.
// - Empty enable lets transmit-buffer-empty set the interrupt.
// - One 8-bit data location: written for transmit, read for receive.
// - Unit off empties buffers, resets counter, clears transmitter and receiver enables and returns status flags to their reset values.
// - Nine-bit select chooses 8 or 9 data bits; ninth bits held apart.
// - Turning transmitter on leaves the transmit-buffer-empty flag set.
`timescale 1ns/1ps
`include "uart_control_cfg.svh"

module uart_control (
	input  wire logic        i_mclk,
	input  wire logic        i_srst,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	input  wire logic        i_rx,
	output logic             o_tx,
	output logic             o_tx_oe,
	output logic             o_rx_owned,
	input  wire logic        i_low_power,
	output logic             o_wake,
	output logic             o_irq
);

	uart_control_pkg::state_type s;
	uart_control_pkg::state_type next_s;

	logic       tick;
	logic       pre_en;
	logic       tx_run;
	logic       rx_run;
	logic       rx_done;
	logic       addr_bit;
	logic       rx_ev;
	logic [8:0] word;
	logic [7:0] ofs;
	logic [2:0] w1c;

	function automatic logic [3:0] last_bit(input logic nine);
		last_bit = nine ? `LAST_BIT_NINE : `LAST_BIT_EIGHT;
	endfunction : last_bit

	function automatic logic bit_end(input logic t, input logic [3:0] cnt);
		bit_end = t && (cnt == `SAMPLE_LAST);
	endfunction : bit_end

	always_comb begin
		next_s = s;
		tick = 1'b0;
		rx_done = 1'b0;
		rx_ev = 1'b0;
		w1c = 3'h0;
		ofs = i_haddr[7:0];
		word = s.nine_bit ? s.rx_shift : {1'b0, s.rx_shift[8:1]};
		addr_bit = s.nine_bit ? word[8] : word[7];
		tx_run = s.unit_on && s.ctrl_two[`C2_TX_ON];
		rx_run = s.unit_on && s.ctrl_two[`C2_RX_ON];
		pre_en = s.high_speed_live || (s.pre == `LOW_SPEED_PRE);
		next_s.rx_prev = i_rx;
		next_s.hreadyout = 1'b1;

		// Baud generator; prescale of 4 makes the 64/16 ratio
		if (!s.unit_on) begin
			next_s.pre = 2'h0;
			next_s.baud_cnt = 8'h00;
			next_s.high_speed_live = s.ctrl_two[`C2_HIGH_SPEED];
		end else begin
			next_s.pre = s.pre + 2'h1;
			if (pre_en) begin
				if (s.baud_cnt == 8'h00) begin
					tick = 1'b1;
					next_s.baud_cnt = s.divisor;
					// Latched only here or with the unit off, so speed changes only at a counter reload
					next_s.high_speed_live = s.ctrl_two[`C2_HIGH_SPEED];
				end else begin
					next_s.baud_cnt = s.baud_cnt - 8'h01;
				end
			end
		end

		// Transmitter
		if (!tx_run) begin
			next_s.tx_st = uart_control_pkg::TX_IDLE;
			next_s.tx_empty = 1'b1;
			next_s.tx_idle = 1'b1;
			next_s.tx_pin = 1'b1;
		end else begin
			if (tick)
				next_s.tx_tick = s.tx_tick + 4'h1;
			case (s.tx_st)
			uart_control_pkg::TX_IDLE: begin
				if (!s.tx_empty) begin
					next_s.tx_shift = {s.tx_ninth, s.hold};
					next_s.tx_empty = 1'b1;
					next_s.tx_idle = 1'b0;
					next_s.tx_tick = 4'h0;
					next_s.tx_pin = 1'b0;
					next_s.tx_st = uart_control_pkg::TX_START;
				end
			end
			uart_control_pkg::TX_START: begin
				if (bit_end(tick, s.tx_tick)) begin
					next_s.tx_bits = 4'h0;
					next_s.tx_pin = s.tx_shift[0];
					next_s.tx_st = uart_control_pkg::TX_DATA;
				end
			end
			uart_control_pkg::TX_DATA: begin
				if (bit_end(tick, s.tx_tick)) begin
					next_s.tx_shift = {1'b1, s.tx_shift[8:1]};
					next_s.tx_bits = s.tx_bits + 4'h1;
					next_s.tx_pin = s.tx_shift[1];
					if (s.tx_bits == last_bit(s.nine_bit)) begin
						next_s.tx_pin = 1'b1;
						next_s.tx_st = uart_control_pkg::TX_STOP;
					end
				end
			end
			uart_control_pkg::TX_STOP: begin
				if (bit_end(tick, s.tx_tick)) begin
					next_s.tx_idle = s.tx_empty;
					next_s.tx_st = uart_control_pkg::TX_IDLE;
				end
			end
			default: next_s.tx_st = uart_control_pkg::TX_IDLE;
			endcase
		end

		// Bus: read data and read side effects at the address phase
		next_s.ap_valid = i_hsel && i_htrans[1] && i_hready;
		next_s.ap_write = i_hwrite;
		next_s.ap_addr = ofs;
		if (next_s.ap_valid && !i_hwrite) begin
			case (ofs)
			`OFS_CTRL_ONE:
				next_s.hrdata = {24'h00_0000, s.unit_on, s.nine_bit, 4'h0,
					s.rx_ninth, 1'b0};
			`OFS_CTRL_TWO: next_s.hrdata = {24'h00_0000, s.ctrl_two};
			`OFS_DATA: begin
				next_s.hrdata = {24'h00_0000, s.rx_data};
				next_s.rx_avail = 1'b0;
				next_s.overrun = 1'b0;
			end
			`OFS_DIVISOR: next_s.hrdata = {24'h00_0000, s.divisor};
			`OFS_STATUS:
				next_s.hrdata = {27'h000_0000, s.overrun, s.rx_idle,
					s.rx_avail, s.tx_idle, s.tx_empty};
			`OFS_IRQ_STATUS: next_s.hrdata = {29'h0000_0000, s.irq_stat};
			`OFS_IRQ_MASK: next_s.hrdata = {29'h0000_0000, s.irq_mask};
			default: next_s.hrdata = 32'h0000_0000;
			endcase
		end

		// Bus: writes in the data phase
		if (s.ap_valid && s.ap_write) begin
			case (s.ap_addr)
			`OFS_CTRL_ONE: begin
				next_s.unit_on = i_hwdata[`C1_UNIT_ON];
				next_s.nine_bit = i_hwdata[`C1_NINE_BIT];
				next_s.tx_ninth = i_hwdata[`C1_TX_NINTH];
			end
			`OFS_CTRL_TWO: next_s.ctrl_two = i_hwdata[7:0];
			`OFS_DATA: begin
				if (tx_run) begin
					next_s.hold = i_hwdata[7:0];
					next_s.tx_empty = 1'b0;
					next_s.tx_idle = 1'b0;
				end
			end
			`OFS_DIVISOR: next_s.divisor = i_hwdata[7:0];
			`OFS_IRQ_STATUS: w1c = i_hwdata[2:0];
			`OFS_IRQ_MASK: next_s.irq_mask = i_hwdata[2:0];
			default: ;
			endcase
		end

		// Receiver, 16 samples per bit
		if (!rx_run) begin
			next_s.rx_st = uart_control_pkg::RX_IDLE;
			next_s.rx_idle = 1'b1;
		end else begin
			if (tick)
				next_s.rx_tick = s.rx_tick + 4'h1;
			case (s.rx_st)
			uart_control_pkg::RX_IDLE: begin
				if (s.rx_prev && !i_rx) begin
					next_s.rx_tick = 4'h0;
					next_s.rx_idle = 1'b0;
					next_s.rx_st = uart_control_pkg::RX_START;
				end
			end
			uart_control_pkg::RX_START: begin
				if (tick && s.rx_tick == `SAMPLE_MID) begin
					next_s.rx_tick = 4'h0;
					next_s.rx_bits = 4'h0;
					// A glitch shorter than half a bit is no start bit
					if (i_rx) begin
						next_s.rx_idle = 1'b1;
						next_s.rx_st = uart_control_pkg::RX_IDLE;
					end else begin
						next_s.rx_st = uart_control_pkg::RX_DATA;
					end
				end
			end
			uart_control_pkg::RX_DATA: begin
				if (bit_end(tick, s.rx_tick)) begin
					next_s.rx_shift = {i_rx, s.rx_shift[8:1]};
					next_s.rx_bits = s.rx_bits + 4'h1;
					if (s.rx_bits == last_bit(s.nine_bit))
						next_s.rx_st = uart_control_pkg::RX_STOP;
				end
			end
			uart_control_pkg::RX_STOP: begin
				if (bit_end(tick, s.rx_tick)) begin
					rx_done = 1'b1;
					next_s.rx_idle = 1'b1;
					next_s.rx_st = uart_control_pkg::RX_IDLE;
					if (s.ctrl_two[`C2_ADDR_DETECT] && !addr_bit) begin
						next_s.rx_st = uart_control_pkg::RX_IDLE;
					end else if (next_s.rx_avail) begin
						next_s.overrun = 1'b1;
					end else begin
						next_s.rx_data = word[7:0];
						next_s.rx_ninth = word[8];
						next_s.rx_avail = 1'b1;
					end
				end
			end
			default: next_s.rx_st = uart_control_pkg::RX_IDLE;
			endcase
		end

		// Unit off: status back to its empty state
		if (!next_s.unit_on) begin
			next_s.ctrl_two[`C2_TX_ON] = 1'b0;
			next_s.ctrl_two[`C2_RX_ON] = 1'b0;
			next_s.rx_avail = 1'b0;
			next_s.overrun = 1'b0;
			next_s.tx_empty = 1'b1;
			next_s.tx_idle = 1'b1;
			next_s.rx_idle = 1'b1;
		end

		// Interrupt flags; a new event wins over a clear
		rx_ev = (!s.rx_avail && next_s.rx_avail) || (!s.overrun && next_s.overrun);
		next_s.irq_stat = s.irq_stat & ~w1c;
		if (rx_ev && s.ctrl_two[`C2_RX_IE])
			next_s.irq_stat[`IRQ_RECEIVE] = 1'b1;
		if (s.tx_idle && s.ctrl_two[`C2_TX_IDLE_IE])
			next_s.irq_stat[`IRQ_TX_IDLE] = 1'b1;
		if (s.tx_empty && s.ctrl_two[`C2_TX_EMPTY_IE])
			next_s.irq_stat[`IRQ_TX_EMPTY] = 1'b1;
		next_s.irq = |(next_s.irq_stat & next_s.irq_mask);

		// Pins
		next_s.tx_oe = next_s.unit_on && next_s.ctrl_two[`C2_TX_ON];
		next_s.rx_owned = next_s.unit_on && next_s.ctrl_two[`C2_RX_ON];
		if (!next_s.tx_oe) begin
			next_s.tx_pin = 1'b1;
			// Cut frame dropped with the pin, not a cycle later
			next_s.tx_st = uart_control_pkg::TX_IDLE;
			next_s.tx_empty = 1'b1;
			next_s.tx_idle = 1'b1;
		end
		if (!next_s.rx_owned) begin
			next_s.rx_st = uart_control_pkg::RX_IDLE;
			next_s.rx_idle = 1'b1;
		end
		next_s.wake = s.ctrl_two[`C2_WAKE] && i_low_power && s.rx_prev
			&& !i_rx;
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			s <= '0;
			s.ctrl_two <= `CTRL_TWO_RESET;
			s.divisor <= `DIVISOR_RESET;
			s.irq_mask <= `IRQ_MASK_RESET;
			s.tx_st <= uart_control_pkg::TX_IDLE;
			s.rx_st <= uart_control_pkg::RX_IDLE;
			s.tx_empty <= 1'b1;
			s.tx_idle <= 1'b1;
			s.rx_idle <= 1'b1;
			s.rx_prev <= 1'b1;
			s.tx_pin <= 1'b1;
			s.hreadyout <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign o_hrdata = s.hrdata;
	assign o_hreadyout = s.hreadyout;
	assign o_hresp = 1'b0;
	assign o_tx = s.tx_pin;
	assign o_tx_oe = s.tx_oe;
	assign o_rx_owned = s.rx_owned;
	assign o_wake = s.wake;
	assign o_irq = s.irq;

	a_tx_pin_owned: assert property (@(posedge i_mclk) disable iff (i_srst)
		o_tx_oe |-> s.unit_on && s.ctrl_two[`C2_TX_ON])
		else $error("TX pin driven while transmitter is off");

	a_tx_off_idle: assert property (@(posedge i_mclk) disable iff (i_srst)
		!o_tx_oe |-> o_tx && s.tx_st == uart_control_pkg::TX_IDLE
		&& s.tx_empty)
		else $error("Transmitter not reset while off");

	a_rx_off_idle: assert property (@(posedge i_mclk) disable iff (i_srst)
		!o_rx_owned |-> s.rx_st == uart_control_pkg::RX_IDLE
		&& o_rx_owned == (s.unit_on && s.ctrl_two[`C2_RX_ON]))
		else $error("Receiver active while off");

	a_baud_reload: assert property (@(posedge i_mclk) disable iff (i_srst)
		(s.unit_on && pre_en && s.baud_cnt == 8'h00)
		|=> s.baud_cnt == $past(s.divisor))
		else $error("Baud counter did not reload the divisor");

	a_addr_drop: assert property (@(posedge i_mclk) disable iff (i_srst)
		(rx_done && s.ctrl_two[`C2_ADDR_DETECT] && !addr_bit && !s.rx_avail)
		|=> !s.rx_avail && !s.irq_stat[`IRQ_RECEIVE]
		|| $past(s.irq_stat[`IRQ_RECEIVE]))
		else $error("Data word kept under address detect");

	a_irq_level: assert property (@(posedge i_mclk) disable iff (i_srst)
		o_irq == |(s.irq_stat & s.irq_mask))
		else $error("Interrupt output disagrees with masked status");

	a_unit_off: assert property (@(posedge i_mclk) disable iff (i_srst)
		!s.unit_on |-> s.tx_empty && s.tx_idle && !s.rx_avail
		&& !s.overrun && !s.ctrl_two[`C2_TX_ON])
		else $error("Unit off but status not in empty state");

	a_wake_gated: assert property (@(posedge i_mclk) disable iff (i_srst)
		!s.ctrl_two[`C2_WAKE] |=> !o_wake)
		else $error("Wake raised while wake is disabled");

	a_rx_ie_gate: assert property (@(posedge i_mclk) disable iff (i_srst)
		(rx_ev && s.ctrl_two[`C2_RX_IE]) |=> s.irq_stat[`IRQ_RECEIVE])
		else $error("Receive event lost its interrupt flag");

	a_tx_on_empty: assert property (@(posedge i_mclk) disable iff (i_srst)
		$rose(s.ctrl_two[`C2_TX_ON]) |-> s.tx_empty)
		else $error("Transmit empty flag clear after enable");

	a_speed_latch: assert property (@(posedge i_mclk) disable iff (i_srst)
		(s.unit_on && !(pre_en && s.baud_cnt == 8'h00))
		|=> $stable(s.high_speed_live))
		else $error("Speed mode changed between counter reloads");

	a_addr_keep: assert property (@(posedge i_mclk) disable iff (i_srst)
		(rx_done && s.ctrl_two[`C2_ADDR_DETECT] && addr_bit
		&& !s.rx_avail && !(s.ap_valid && s.ap_write))
		|=> s.rx_avail)
		else $error("Address word not kept under address detect");

endmodule : uart_control

// [logic/uart_control_cfg.svh]
// Offsets, field positions, reset values and timing counts of the serial port
`ifndef UART_CONTROL_CFG_SVH
`define UART_CONTROL_CFG_SVH

`define OFS_CTRL_ONE    8'h00
`define OFS_CTRL_TWO    8'h04
`define OFS_DATA        8'h08
`define OFS_DIVISOR     8'h0C
`define OFS_STATUS      8'h10
`define OFS_IRQ_STATUS  8'h14
`define OFS_IRQ_MASK    8'h18

`define C1_UNIT_ON      7
`define C1_NINE_BIT     6
`define C1_RX_NINTH     1
`define C1_TX_NINTH     0

`define C2_TX_ON        7
`define C2_RX_ON        6
`define C2_HIGH_SPEED   5
`define C2_ADDR_DETECT  4
`define C2_WAKE         3
`define C2_RX_IE        2
`define C2_TX_IDLE_IE   1
`define C2_TX_EMPTY_IE  0

`define ST_OVERRUN      4
`define ST_RX_IDLE      3
`define ST_RX_AVAIL     2
`define ST_TX_IDLE      1
`define ST_TX_EMPTY     0

`define IRQ_TX_EMPTY    0
`define IRQ_TX_IDLE     1
`define IRQ_RECEIVE     2

`define CTRL_TWO_RESET  8'h00
`define DIVISOR_RESET   8'h00
`define IRQ_MASK_RESET  3'h0

`define LOW_SPEED_PRE   2'h3
`define SAMPLE_LAST     4'hF
`define SAMPLE_MID      4'h7
`define LAST_BIT_EIGHT  4'h7
`define LAST_BIT_NINE   4'h8

`endif

// [logic/uart_control_pkg.sv]
// Types of the serial port control block
package uart_control_pkg;

	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_type;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;

	typedef struct packed {
		logic         unit_on;
		logic         nine_bit;
		logic         tx_ninth;
		logic         rx_ninth;
		logic [7:0]   ctrl_two;
		logic [7:0]   divisor;
		logic [1:0]   pre;
		logic [7:0]   baud_cnt;
		logic         high_speed_live;
		logic [7:0]   hold;
		logic         tx_empty;
		logic         tx_idle;
		tx_state_type tx_st;
		logic [8:0]   tx_shift;
		logic [3:0]   tx_bits;
		logic [3:0]   tx_tick;
		rx_state_type rx_st;
		logic [8:0]   rx_shift;
		logic [3:0]   rx_bits;
		logic [3:0]   rx_tick;
		logic [7:0]   rx_data;
		logic         rx_avail;
		logic         overrun;
		logic         rx_idle;
		logic         rx_prev;
		logic [2:0]   irq_stat;
		logic [2:0]   irq_mask;
		logic         ap_valid;
		logic         ap_write;
		logic [7:0]   ap_addr;
		logic [31:0]  hrdata;
		logic         hreadyout;
		logic         irq;
		logic         tx_pin;
		logic         tx_oe;
		logic         rx_owned;
		logic         wake;
	} state_type;

endpackage : uart_control_pkg

// [sim/serial_node.sv]
// Remote serial node that sends and decodes frames on the link
`timescale 1ns/1ps

module serial_node (
	input  wire logic i_mclk,
	input  wire logic i_line_in,
	output logic      o_line_out
);
	// Line rests high between frames, as an idle link does
	initial o_line_out = 1'b1;

	// Start bit, data LSB first, one stop bit, bt clocks a bit
	task automatic send(input logic [8:0] d, input int nb, input int bt);
		for (int i = 0; i < nb + 2; i++) begin
			o_line_out <= (i == 0) ? 1'b0 : (i > nb) ? 1'b1 : d[i - 1];
			repeat (bt) @(posedge i_mclk);
		end
	endtask : send

	// Stop bit lands at position nb; sampled mid-bit from the start edge
	task automatic recv(output logic [9:0] d, input int nb, input int bt);
		d = '0;
		while (i_line_in !== 1'b0) @(posedge i_mclk);
		repeat (bt / 2) @(posedge i_mclk);
		for (int i = 0; i <= nb; i++) begin
			repeat (bt) @(posedge i_mclk);
			d[i] = i_line_in;
		end
	endtask : recv
endmodule : serial_node

// [sim/testbench.sv]
// Self-checking bench of the serial port control block
`timescale 1ns/1ps
`include "uart_control_cfg.svh"

module testbench;
	logic        i_mclk;
	logic        i_srst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        rx_line;
	logic        tx;
	logic        tx_oe;
	logic        rx_owned;
	logic        low_power;
	logic        wake;
	logic        irq;
	wire         tx_line;
	int          n_errors;
	int          n_tests;
	int          cycles;
	int          wake_n;

	// Released TX pin rests on its pull-up
	assign tx_line = tx_oe ? tx : 1'b1;

	uart_control i_uart_control (
		.i_mclk(i_mclk), .i_srst(i_srst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
		.i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
		.o_hreadyout(hreadyout), .o_hresp(hresp), .i_rx(rx_line),
		.o_tx(tx), .o_tx_oe(tx_oe), .o_rx_owned(rx_owned),
		.i_low_power(low_power), .o_wake(wake), .o_irq(irq)
	);

	serial_node i_serial_node (
		.i_mclk(i_mclk), .i_line_in(tx_line), .o_line_out(rx_line)
	);

	initial begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end

	// Frames run at most 704 clocks; the whole run stays far below this
	always @(posedge i_mclk) begin
		cycles++;
		if (wake === 1'b1)
			wake_n++;
		if (cycles == 60000) begin
			n_errors++;
			$display("BAD %0t timeout", $time);
			complete_run();
		end
	end

	task automatic complete_run();
		$display("Counts: %0d tests, %0d errors", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] g, e, input string m);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : check

	// One single AHB-Lite transfer; waits on hready in both phases
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge i_mclk);
		hsel   <= 1'b1;
		haddr  <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge i_mclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge i_mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] x);
		bus(1'b0, a, 32'h0000_0000, x);
	endtask : rd

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
		input string m);
		logic [31:0] x;
		rd(a, x);
		check(x, e, m);
	endtask : rd_chk

	task automatic t_reset();
		rd_chk(`OFS_CTRL_TWO, 32'h0000_0000, "ctrl two reset");
		rd_chk(`OFS_STATUS, 32'h0000_000B, "status reset");
		rd_chk(`OFS_IRQ_MASK, 32'h0000_0000, "mask reset");
		wr(8'h1C, 32'h0000_00FF);
		rd_chk(8'h1C, 32'h0000_0000, "unmapped");
		check({irq, hresp}, 2'h0, "irq resp");
		$display("test reset done");
	endtask : t_reset

	task automatic t_pins();
		wr(`OFS_CTRL_TWO, 32'h0000_00E4);
		rd_chk(`OFS_CTRL_TWO, 32'h0000_0024, "enables held");
		check(tx_oe, 1'b0, "tx oe unit off");
		wr(`OFS_CTRL_ONE, 32'h0000_0080);
		wr(`OFS_CTRL_TWO, 32'h0000_00C0);
		repeat (2) @(posedge i_mclk);
		check(tx_oe, 1'b1, "tx oe on");
		check(rx_owned, 1'b1, "rx owned on");
		rd_chk(`OFS_STATUS, 32'h0000_000B, "empty on tx on");
		wr(`OFS_CTRL_TWO, 32'h0000_0000);
		repeat (2) @(posedge i_mclk);
		check({tx_oe, tx}, 2'h1, "tx released");
		check(rx_owned, 1'b0, "rx released");
		$display("test pins done");
	endtask : t_pins

	// High speed N=0, high speed N=2, low speed N=0 with nine bits
	task automatic t_tx();
		logic [9:0] got;
		int         bt[3] = '{16, 48, 64};
		for (int k = 0; k < 3; k++) begin
			wr(`OFS_CTRL_ONE, (k == 2) ? 32'h0000_00C1 : 32'h0000_0080);
			wr(`OFS_DIVISOR, (k == 1) ? 32'h0000_0002 : 32'h0000_0000);
			wr(`OFS_CTRL_TWO, (k < 2) ? 32'h0000_00A0 : 32'h0000_0080);
			wr(`OFS_DATA, 32'h0000_00A5);
			i_serial_node.recv(got, (k == 2) ? 9 : 8, bt[k]);
			check(got, (k == 2) ? 10'h3A5 : 10'h1A5, "tx frame");
			repeat (bt[k]) @(posedge i_mclk);
		end
		$display("test transmit done");
	endtask : t_tx

	task automatic t_rx();
		logic [31:0] x;
		wr(`OFS_CTRL_ONE, 32'h0000_0080);
		wr(`OFS_CTRL_TWO, 32'h0000_0064);
		wr(`OFS_IRQ_MASK, 32'h0000_0004);
		i_serial_node.send(9'h03C, 8, 16);
		repeat (24) @(posedge i_mclk);
		check(irq, 1'b1, "rx irq");
		rd(`OFS_STATUS, x);
		check(x[`ST_RX_AVAIL], 1'b1, "rx avail");
		rd_chk(`OFS_DATA, 32'h0000_003C, "rx data");
		wr(`OFS_IRQ_STATUS, 32'h0000_0004);
		repeat (2) @(posedge i_mclk);
		check(irq, 1'b0, "irq cleared");
		i_serial_node.send(9'h011, 8, 16);
		i_serial_node.send(9'h022, 8, 16);
		repeat (24) @(posedge i_mclk);
		rd(`OFS_STATUS, x);
		check(x[`ST_OVERRUN], 1'b1, "overrun");
		rd_chk(`OFS_DATA, 32'h0000_0011, "first kept");
		wr(`OFS_IRQ_STATUS, 32'h0000_0004);
		wr(`OFS_CTRL_TWO, 32'h0000_0060);
		i_serial_node.send(9'h055, 8, 16);
		repeat (24) @(posedge i_mclk);
		rd(`OFS_IRQ_STATUS, x);
		check(x[`IRQ_RECEIVE], 1'b0, "rx irq disabled");
		rd_chk(`OFS_DATA, 32'h0000_0055, "rx data");
		$display("test receive done");
	endtask : t_rx

	task automatic t_txirq();
		wr(`OFS_CTRL_TWO, 32'h0000_0081);
		wr(`OFS_IRQ_MASK, 32'h0000_0001);
		repeat (2) @(posedge i_mclk);
		check(irq, 1'b1, "empty irq");
		wr(`OFS_IRQ_MASK, 32'h0000_0002);
		repeat (2) @(posedge i_mclk);
		check(irq, 1'b0, "idle irq off");
		wr(`OFS_CTRL_TWO, 32'h0000_0082);
		repeat (2) @(posedge i_mclk);
		check(irq, 1'b1, "idle irq");
		wr(`OFS_CTRL_TWO, 32'h0000_0080);
		wr(`OFS_IRQ_STATUS, 32'h0000_0003);
		rd_chk(`OFS_IRQ_STATUS, 32'h0000_0000, "tx irqs off");
		$display("test tx irq done");
	endtask : t_txirq

	task automatic t_addr();
		logic [31:0] x;
		wr(`OFS_CTRL_TWO, 32'h0000_0074);
		wr(`OFS_IRQ_MASK, 32'h0000_0004);
		i_serial_node.send(9'h012, 8, 16);
		repeat (24) @(posedge i_mclk);
		rd(`OFS_STATUS, x);
		check({x[`ST_RX_AVAIL], irq}, 2'h0, "data dropped");
		i_serial_node.send(9'h085, 8, 16);
		repeat (24) @(posedge i_mclk);
		check(irq, 1'b1, "address irq");
		rd_chk(`OFS_DATA, 32'h0000_0085, "address kept");
		wr(`OFS_IRQ_STATUS, 32'h0000_0004);
		$display("test address done");
	endtask : t_addr

	// 0xFE gives exactly one falling edge per frame
	task automatic t_wake();
		int n0;
		low_power <= 1'b1;
		wr(`OFS_CTRL_TWO, 32'h0000_0008);
		n0 = wake_n;
		i_serial_node.send(9'h0FE, 8, 16);
		check(wake_n - n0, 1, "wake pulse");
		wr(`OFS_CTRL_TWO, 32'h0000_0000);
		n0 = wake_n;
		i_serial_node.send(9'h0FE, 8, 16);
		check(wake_n - n0, 0, "no wake");
		low_power <= 1'b0;
		$display("test wake done");
	endtask : t_wake

	// All-zero data keeps the line low long enough to cut it mid-frame
	task automatic t_abort();
		wr(`OFS_CTRL_TWO, 32'h0000_00E0);
		wr(`OFS_DATA, 32'h0000_0000);
		repeat (40) @(posedge i_mclk);
		wr(`OFS_CTRL_TWO, 32'h0000_0060);
		repeat (2) @(posedge i_mclk);
		check({tx_oe, tx}, 2'h1, "tx abort");
		wr(`OFS_CTRL_TWO, 32'h0000_00E0);
		wr(`OFS_DATA, 32'h0000_0000);
		repeat (40) @(posedge i_mclk);
		wr(`OFS_CTRL_ONE, 32'h0000_0000);
		repeat (2) @(posedge i_mclk);
		check({tx_oe, rx_owned}, 2'h0, "unit off pins");
		rd_chk(`OFS_STATUS, 32'h0000_000B, "unit off flags");
		rd_chk(`OFS_CTRL_TWO, 32'h0000_0020, "unit off ctrl");
		$display("test abort done");
	endtask : t_abort

	initial begin
		i_srst    = 1'b1;
		hsel      = 1'b0;
		haddr     = 32'h0000_0000;
		htrans    = 2'h0;
		hwrite    = 1'b0;
		hsize     = 3'h2;
		hwdata    = 32'h0000_0000;
		low_power = 1'b0;
		repeat (5) @(posedge i_mclk);
		i_srst <= 1'b0;
		t_reset();
		t_pins();
		t_tx();
		t_rx();
		t_txirq();
		t_addr();
		t_wake();
		t_abort();
		complete_run();
	end
endmodule : testbench
